// ---- logic/msc_regs.svh ----
// Purpose: Constants for the motion signal conditioning block.
// Assumes: 100 MHz system clock.
// Notes:   Timing counts are derived from times in the top module.
`ifndef MSC_REGS_SVH
`define MSC_REGS_SVH

`define MSC_AXES            4
`define MSC_CLK_MHZ         100
// Filter code 0 delay and its noise rejection, in ns
`define MSC_FILT_SHORT_NS   2000
`define MSC_FILT_SHORT_REJ_NS 1750
// Filter code 1 delay in us; each further code doubles it
`define MSC_FILT_LONG_US    256
`define MSC_FILT_CW         21
`define MSC_FILT_CODES      3
`define MSC_FILT_GROUPS     5

// Command pulse output formats
`define MSC_FMT_DUAL_HI     3'h0
`define MSC_FMT_DUAL_LO     3'h1
`define MSC_FMT_PD_HH       3'h2
`define MSC_FMT_PD_HL       3'h3
`define MSC_FMT_PD_LH       3'h4
`define MSC_FMT_PD_LL       3'h5

// Quadrature rate divider codes
`define MSC_DIV_1           2'h0
`define MSC_DIV_2           2'h1
`define MSC_DIV_4           2'h2

// Bit positions in the per-axis conditioned input vector
`define MSC_SIG_LIMP        0
`define MSC_SIG_LIMN        1
`define MSC_SIG_HOME        2
`define MSC_SIG_APPR        3
`define MSC_SIG_ZPH         4
`define MSC_SIG_SETL        5
`define MSC_SIG_FALT        6
`define MSC_SIG_MANP        7
`define MSC_SIG_MANN        8
`define MSC_SIG_GI3         9
`define MSC_SIG_ENCA        10
`define MSC_SIG_ENCB        11
`define MSC_SIG_NUM         12

`define MSC_CNT_W           32
`define MSC_RAW_W           34
`endif

// ---- logic/msc_pkg.sv ----
// Purpose: Types of the motion signal conditioning block.
// Assumes: Nothing beyond the constants header.
// Notes:   Enum codes are left to the tool.
package msc_pkg;
  typedef enum logic {MSC_STOP_IMMED, MSC_STOP_DECEL} msc_stop_e;
  typedef enum logic {MSC_ENC_QUAD, MSC_ENC_UPDN}     msc_enc_e;
  typedef logic [2:0] msc_code_t;
endpackage : msc_pkg

// ---- logic/msc_filter.sv ----
// Purpose: Three-stage synchroniser plus stable-time digital filter per input.
// Assumes: Inputs are asynchronous pins.
// Notes:   A bypassed bit still passes the synchroniser.
`timescale 1ns/1ps
module msc_filter #(
  parameter int N  = 12,
  parameter int CW = 21
) (
  input  wire logic          mclk,
  input  wire logic          nrst,
  input  wire logic [N-1:0]  pin_raw,
  input  wire logic [N-1:0]  filt_on,
  input  wire logic [CW-1:0] delay_lim,
  output logic      [N-1:0]  pin_clean
);
  logic [N-1:0]  s1_q;
  logic [N-1:0]  s2_q;
  logic [N-1:0]  s3_q;
  logic [CW-1:0] cnt_q [N];

  if (N < 1 || CW < 2) begin : g_bad
    $error("msc_filter: N and CW too small");
  end

  // A level counts once stages two and three agree; stage one feeds only stage two
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_q      <= '0;
      s2_q      <= '0;
      s3_q      <= '0;
      pin_clean <= '0;
      for (int i = 0; i < N; i++) cnt_q[i] <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < N; i++) begin
        if (s2_q[i] != s3_q[i] || s3_q[i] == pin_clean[i]) begin
          cnt_q[i] <= '0;
        end else if (!filt_on[i] || cnt_q[i] >= delay_lim) begin
          pin_clean[i] <= s3_q[i];
          cnt_q[i]     <= '0;
        end else begin
          cnt_q[i] <= cnt_q[i] + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // A filtered bit moves only after its level held for the full delay
  filt_hold_a: assert property (
    (filt_on[0] && $stable(filt_on[0]) && $stable(delay_lim) && !$stable(pin_clean[0]))
    |-> ($past(cnt_q[0]) >= delay_lim))
    else $error("filtered input moved before its delay ran out");
endmodule : msc_filter

// ---- logic/msc_top.sv ----
// Purpose: Per-axis pulse output format, signal polarity, filters and encoder counting.
// Assumes: Profile logic supplies one-cycle step requests with a direction level.
// Notes:   Pins pass through msc_filter; every output is registered.
`timescale 1ns/1ps
`include "msc_regs.svh"

// Overview of operation
// - Six pulse formats by code; codes 0 and 1 give separate CW and CCW lines.
// - Codes 2 to 5 give one pulse line plus one direction level line.
// - Every polarity is set per axis and never touches another axis.
// - Each axis has polarity for both limits, home, approach, Z-phase, drive power.
// - Drive-settled input has enable and level; disabled means it is ignored.
// - Drive-fault input has enable and level; disabled fault never affects the axis.
// - Spare input three has its own enable and level, separate from the others.
// - Settled, fault, spare, encoder and filter settings load only into selected axes.
// - Feedback counts quadrature A/B or separate up and down pulses by mode.
// - Quadrature divider code 0 is 1:1, 1 is 1:2, 2 is 1:4.
// - Filter code 0 delays 2 us and rejects noise up to 1.75 us.
// - Codes 1 to 7 double from 256 us to 16.384 ms; rejection is 7/8.
// - Five filter enables each route one input group through or around the filter.
// - Group one: emergency stop, both limits, home and approach inputs.
// - Group two: Z-phase only; group three: drive-settled and drive-fault.
// - Group four: manual pulse inputs both ways; group five: spare input three.
module msc_top #(
  parameter int AXES           = `MSC_AXES,
  parameter int FILT_SHORT_CYC = (`MSC_FILT_SHORT_NS * `MSC_CLK_MHZ + 999) / 1000,
  parameter int FILT_LONG_CYC  = `MSC_FILT_LONG_US * `MSC_CLK_MHZ
) (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire logic [AXES-1:0]              cmd_pulse,
  input  wire logic [AXES-1:0]              cmd_dir,
  input  wire logic [3*AXES-1:0]            pulse_mode,
  input  wire logic [AXES-1:0]              limit_pol,
  input  wire logic [AXES-1:0]              home_pol,
  input  wire logic [AXES-1:0]              approach_pol,
  input  wire logic [AXES-1:0]              zphase_pol,
  input  wire logic [AXES-1:0]              power_pol,
  input  wire logic [AXES-1:0]              power_on,
  input  wire logic                         sel_wr,
  input  wire logic [AXES-1:0]              sel_axes,
  input  wire logic                         sel_settled_en,
  input  wire logic                         sel_settled_lvl,
  input  wire logic                         sel_fault_en,
  input  wire logic                         sel_fault_lvl,
  input  wire logic                         sel_gi3_en,
  input  wire logic                         sel_gi3_lvl,
  input  wire msc_pkg::msc_enc_e            sel_enc_mode,
  input  wire logic [1:0]                   sel_enc_div,
  input  wire msc_pkg::msc_code_t           sel_filt_code,
  input  wire logic [`MSC_FILT_GROUPS-1:0]  sel_filt_en,
  input  wire msc_pkg::msc_stop_e           sel_stop_mode,
  input  wire logic                         emergency_stop_input,
  input  wire logic [2*AXES-1:0]            travel_limit_pair,
  input  wire logic [AXES-1:0]              home_sensor_pin,
  input  wire logic [AXES-1:0]              approach_sensor_pin,
  input  wire logic [AXES-1:0]              z_phase_input,
  input  wire logic [AXES-1:0]              settled_pin,
  input  wire logic [AXES-1:0]              fault_pin,
  input  wire logic [2*AXES-1:0]            manual_pulse_inputs,
  input  wire logic [AXES-1:0]              general_input_three,
  input  wire logic [AXES-1:0]              enc_a,
  input  wire logic [AXES-1:0]              enc_b,
  output logic      [AXES-1:0]              pulse_a_q,
  output logic      [AXES-1:0]              pulse_b_q,
  output logic      [AXES-1:0]              pulse_taken_q,
  output logic      [AXES-1:0]              decel_req_q,
  output logic      [AXES-1:0]              drive_power_q,
  output logic                              estop_act_q,
  output logic      [AXES-1:0]              limit_pos_act_q,
  output logic      [AXES-1:0]              limit_neg_act_q,
  output logic      [AXES-1:0]              home_act_q,
  output logic      [AXES-1:0]              approach_act_q,
  output logic      [AXES-1:0]              zphase_act_q,
  output logic      [AXES-1:0]              settled_ok_q,
  output logic      [AXES-1:0]              fault_act_q,
  output logic      [AXES-1:0]              gi3_act_q,
  output logic      [AXES-1:0]              manual_up_q,
  output logic      [AXES-1:0]              manual_dn_q,
  output logic      [`MSC_CNT_W*AXES-1:0]   enc_count_q
);
  import msc_pkg::*;

  localparam int CW = `MSC_FILT_CW;
  localparam int NS = `MSC_SIG_NUM;
  localparam int RW = `MSC_RAW_W;
  localparam int QW = `MSC_CNT_W;
  localparam int MAX_SHIFT = (1 << `MSC_FILT_CODES) - 2;

  // The longest delay must still fit the filter counter
  if (AXES < 1 || FILT_SHORT_CYC < 1 || FILT_LONG_CYC < 1 ||
      (longint'(FILT_LONG_CYC) << MAX_SHIFT) >= (longint'(1) << CW)) begin : g_bad
    $error("msc_top: parameters out of range");
  end

  // Per-axis settings loaded through the axis selection, then encoder history and the undivided position
  logic                          settled_en_q [AXES];
  logic                          settled_lvl_q[AXES];
  logic                          fault_en_q   [AXES];
  logic                          fault_lvl_q  [AXES];
  logic                          gi3_en_q     [AXES];
  logic                          gi3_lvl_q    [AXES];
  msc_enc_e                      enc_mode_q   [AXES];
  logic [1:0]                    enc_div_q    [AXES];
  msc_code_t                     filt_code_q  [AXES];
  logic [`MSC_FILT_GROUPS-1:0]   filt_en_q    [AXES];
  msc_stop_e                     stop_mode_q  [AXES];
  logic                          prev_a_q     [AXES];
  logic                          prev_b_q     [AXES];
  logic [RW-1:0]                 raw_q        [AXES];

  wire  [NS-1:0]                 clean        [AXES];
  wire  [RW-1:0]                 raw_d        [AXES];
  wire  [QW-1:0]                 cnt_d        [AXES];
  wire  [AXES-1:0]               pa_d;
  wire  [AXES-1:0]               pb_d;
  wire  [AXES-1:0]               fire_d;
  wire  [AXES-1:0]               decel_d;
  wire  [AXES-1:0]               power_d;
  wire  [AXES-1:0]               lim_p_d;
  wire  [AXES-1:0]               lim_n_d;
  wire  [AXES-1:0]               home_d;
  wire  [AXES-1:0]               appr_d;
  wire  [AXES-1:0]               zph_d;
  wire  [AXES-1:0]               settled_d;
  wire  [AXES-1:0]               fault_d;
  wire  [AXES-1:0]               gi3_d;
  wire                           estop_clean;

  // Active when the pin level equals the configured active level
  function automatic logic f_act(input logic lvl, input logic pol);
    f_act = lvl ~^ pol;
  endfunction : f_act

  // Code 0 is the short filter; codes 1 to 7 double from the long base
  function automatic logic [CW-1:0] f_delay(input msc_code_t code);
    if (code == 3'h0) f_delay = CW'(FILT_SHORT_CYC);
    else              f_delay = CW'(longint'(FILT_LONG_CYC) << (code - 3'h1));
  endfunction : f_delay

  // Returns {b, a}; codes 6 and 7 hold both lines low
  function automatic logic [1:0] f_fmt(input logic [2:0] mode, input logic fire,
                                       input logic dir);
    case (mode)
      `MSC_FMT_DUAL_HI: f_fmt = {fire & ~dir, fire & dir};
      `MSC_FMT_DUAL_LO: f_fmt = ~{fire & ~dir, fire & dir};
      `MSC_FMT_PD_HH:   f_fmt = {dir, fire};
      `MSC_FMT_PD_HL:   f_fmt = {~dir, fire};
      `MSC_FMT_PD_LH:   f_fmt = {dir, ~fire};
      `MSC_FMT_PD_LL:   f_fmt = {~dir, ~fire};
      default:          f_fmt = 2'h0;
    endcase
  endfunction : f_fmt

  // Emergency stop belongs to group one and follows axis 0's delay code
  msc_filter #(.N(1), .CW(CW)) u_estop_filt (
    .mclk      (mclk),
    .nrst      (nrst),
    .pin_raw   (emergency_stop_input),
    .filt_on   (filt_en_q[0][0]),
    .delay_lim (f_delay(filt_code_q[0])),
    .pin_clean (estop_clean)
  );

  // Emergency stop is active low at the pin
  wire estop_d = ~estop_clean;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  for (genvar a = 0; a < AXES; a++) begin : g_ax
    wire [NS-1:0] raw_pins = {enc_b[a], enc_a[a], general_input_three[a],
                              manual_pulse_inputs[2*a+1], manual_pulse_inputs[2*a],
                              fault_pin[a], settled_pin[a], z_phase_input[a],
                              approach_sensor_pin[a], home_sensor_pin[a],
                              travel_limit_pair[2*a+1], travel_limit_pair[2*a]};
    wire [4:0]    fe = filt_en_q[a];
    // Encoder lines are synchronised but never delayed
    wire [NS-1:0] fon = {2'h0, fe[4], fe[3], fe[3], fe[2], fe[2], fe[1],
                         fe[0], fe[0], fe[0], fe[0]};

    msc_filter #(.N(NS), .CW(CW)) u_filt (
      .mclk      (mclk),
      .nrst      (nrst),
      .pin_raw   (raw_pins),
      .filt_on   (fon),
      .delay_lim (f_delay(filt_code_q[a])),
      .pin_clean (clean[a])
    );

    wire [NS-1:0] c = clean[a];
    assign lim_p_d[a]   = f_act(c[`MSC_SIG_LIMP], limit_pol[a]);
    assign lim_n_d[a]   = f_act(c[`MSC_SIG_LIMN], limit_pol[a]);
    assign home_d[a]    = f_act(c[`MSC_SIG_HOME], home_pol[a]);
    assign appr_d[a]    = f_act(c[`MSC_SIG_APPR], approach_pol[a]);
    assign zph_d[a]     = f_act(c[`MSC_SIG_ZPH], zphase_pol[a]);
    assign power_d[a]   = power_on[a] ~^ power_pol[a];
    assign settled_d[a] = ~settled_en_q[a] |
                          f_act(c[`MSC_SIG_SETL], settled_lvl_q[a]);
    assign fault_d[a]   = fault_en_q[a] & f_act(c[`MSC_SIG_FALT], fault_lvl_q[a]);
    assign gi3_d[a]     = gi3_en_q[a] & f_act(c[`MSC_SIG_GI3], gi3_lvl_q[a]);

    // Only the limit in the direction of travel matters; backing off stays free
    wire into_lim  = cmd_dir[a] ? lim_p_d[a] : lim_n_d[a];
    wire hard_stop = estop_d | fault_d[a] |
                     (into_lim & (stop_mode_q[a] == MSC_STOP_IMMED));
    assign fire_d[a]  = cmd_pulse[a] & ~hard_stop;
    assign decel_d[a] = into_lim & (stop_mode_q[a] == MSC_STOP_DECEL);
    assign {pb_d[a], pa_d[a]} = f_fmt(pulse_mode[3*a +: 3], fire_d[a], cmd_dir[a]);

    // Feedback counter keeps sub-counts so a divided count survives reversals
    wire ea    = c[`MSC_SIG_ENCA];
    wire eb    = c[`MSC_SIG_ENCB];
    wire q_mv  = (ea ^ prev_a_q[a]) ^ (eb ^ prev_b_q[a]);
    wire q_up  = prev_b_q[a] ^ ea;
    wire up_e  = ea & ~prev_a_q[a];
    wire dn_e  = eb & ~prev_b_q[a];
    wire updn  = (enc_mode_q[a] == MSC_ENC_UPDN);
    wire inc   = updn ? (up_e & ~dn_e) : (q_mv & q_up);
    wire dec   = updn ? (dn_e & ~up_e) : (q_mv & ~q_up);
    assign raw_d[a] = inc ? raw_q[a] + RW'(1) : (dec ? raw_q[a] - RW'(1) : raw_q[a]);
    assign cnt_d[a] = updn                          ? raw_d[a][QW-1:0] :
                      (enc_div_q[a] == `MSC_DIV_2)  ? raw_d[a][QW:1]   :
                      (enc_div_q[a] == `MSC_DIV_4)  ? raw_d[a][QW+1:2] :
                                                      raw_d[a][QW-1:0];

    pulse_fmt_a: assert property (
      (fire_d[a] && cmd_dir[a] && pulse_mode[3*a +: 3] == `MSC_FMT_DUAL_HI)
      |=> (pulse_a_q[a] && !pulse_b_q[a]))
      else $error("dual channel format drove the wrong line");
    dir_level_a: assert property (
      (pulse_mode[3*a +: 3] == `MSC_FMT_PD_HL) [*2]
      |=> (pulse_b_q[a] == !$past(cmd_dir[a]) &&
           $past(pulse_b_q[a]) == !$past(cmd_dir[a], 2)))
      else $error("direction line did not hold its level");
    lim_stop_a: assert property (
      (cmd_pulse[a] && cmd_dir[a] && lim_p_d[a] && stop_mode_q[a] == MSC_STOP_IMMED)
      |=> !pulse_taken_q[a])
      else $error("pulse passed into an active limit");
    decel_req_a: assert property (
      (!cmd_dir[a] && lim_n_d[a] && stop_mode_q[a] == MSC_STOP_DECEL && !estop_d)
      |=> (decel_req_q[a] && (pulse_taken_q[a] == $past(cmd_pulse[a] & ~fault_d[a]))))
      else $error("decelerating stop handled wrongly");
    settled_off_a: assert property (
      (!settled_en_q[a] && $stable(settled_en_q[a])) |=> settled_ok_q[a])
      else $error("disabled settled input was not ignored");
    fault_off_a: assert property (
      (!fault_en_q[a] && !estop_d && cmd_pulse[a] && !(cmd_dir[a] ? lim_p_d[a] : lim_n_d[a]))
      |=> (pulse_taken_q[a] && !fault_act_q[a]))
      else $error("disabled fault input affected the axis");
    updn_count_a: assert property (
      (enc_mode_q[a] == MSC_ENC_UPDN && up_e && !dn_e) |=> (raw_q[a] == $past(raw_q[a]) + RW'(1)))
      else $error("up pulse did not advance the counter");
    div_scale_a: assert property (
      (enc_mode_q[a] == MSC_ENC_QUAD && enc_div_q[a] == `MSC_DIV_4)
      |=> (enc_count_q[QW*a +: QW] == $past(raw_d[a][QW+1:2])))
      else $error("quarter rate count is wrong");
  end

  // Settings land only in the selected axes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int a = 0; a < AXES; a++) begin
        settled_en_q[a]  <= 1'b0;
        settled_lvl_q[a] <= 1'b0;
        fault_en_q[a]    <= 1'b0;
        fault_lvl_q[a]   <= 1'b0;
        gi3_en_q[a]      <= 1'b0;
        gi3_lvl_q[a]     <= 1'b0;
        enc_mode_q[a]    <= MSC_ENC_QUAD;
        enc_div_q[a]     <= `MSC_DIV_1;
        filt_code_q[a]   <= 3'h0;
        filt_en_q[a]     <= '0;
        stop_mode_q[a]   <= MSC_STOP_IMMED;
      end
    end else begin
      for (int a = 0; a < AXES; a++) begin
        if (sel_wr && sel_axes[a]) begin
          settled_en_q[a]  <= sel_settled_en;
          settled_lvl_q[a] <= sel_settled_lvl;
          fault_en_q[a]    <= sel_fault_en;
          fault_lvl_q[a]   <= sel_fault_lvl;
          gi3_en_q[a]      <= sel_gi3_en;
          gi3_lvl_q[a]     <= sel_gi3_lvl;
          enc_mode_q[a]    <= sel_enc_mode;
          enc_div_q[a]     <= sel_enc_div;
          filt_code_q[a]   <= sel_filt_code;
          filt_en_q[a]     <= sel_filt_en;
          stop_mode_q[a]   <= sel_stop_mode;
        end
      end
    end
  end

  // Encoder history and the undivided position
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int a = 0; a < AXES; a++) begin
        prev_a_q[a] <= 1'b0;
        prev_b_q[a] <= 1'b0;
        raw_q[a]    <= '0;
      end
    end else begin
      for (int a = 0; a < AXES; a++) begin
        prev_a_q[a] <= clean[a][`MSC_SIG_ENCA];
        prev_b_q[a] <= clean[a][`MSC_SIG_ENCB];
        raw_q[a]    <= raw_d[a];
      end
    end
  end

  // Output stage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pulse_a_q       <= '0;
      pulse_b_q       <= '0;
      pulse_taken_q   <= '0;
      decel_req_q     <= '0;
      drive_power_q   <= '0;
      estop_act_q     <= 1'b0;
      limit_pos_act_q <= '0;
      limit_neg_act_q <= '0;
      home_act_q      <= '0;
      approach_act_q  <= '0;
      zphase_act_q    <= '0;
      settled_ok_q    <= '0;
      fault_act_q     <= '0;
      gi3_act_q       <= '0;
      manual_up_q     <= '0;
      manual_dn_q     <= '0;
      enc_count_q     <= '0;
    end else begin
      pulse_a_q       <= pa_d;
      pulse_b_q       <= pb_d;
      pulse_taken_q   <= fire_d;
      decel_req_q     <= decel_d;
      drive_power_q   <= power_d;
      estop_act_q     <= estop_d;
      limit_pos_act_q <= lim_p_d;
      limit_neg_act_q <= lim_n_d;
      home_act_q      <= home_d;
      approach_act_q  <= appr_d;
      zphase_act_q    <= zph_d;
      settled_ok_q    <= settled_d;
      fault_act_q     <= fault_d;
      gi3_act_q       <= gi3_d;
      for (int a = 0; a < AXES; a++) begin
        manual_up_q[a]           <= clean[a][`MSC_SIG_MANP];
        manual_dn_q[a]           <= clean[a][`MSC_SIG_MANN];
        enc_count_q[QW*a +: QW]  <= cnt_d[a];
      end
    end
  end

  sel_keep_a: assert property (
    (sel_wr && !sel_axes[0]) |=> ($stable(filt_code_q[0]) && $stable(fault_en_q[0])))
    else $error("unselected axis settings changed");
  pol_isolate_a: assert property (
    ($stable(clean[0]) && $stable(home_pol[0]) && $changed(home_pol[AXES-1]))
    |=> $stable(home_act_q[0]))
    else $error("polarity of one axis moved another");
  gi3_split_a: assert property (
    (gi3_en_q[0] && !fault_en_q[0] && $stable(gi3_en_q[0]) && $stable(fault_en_q[0]))
    |=> (!fault_act_q[0] && (gi3_act_q[0] ==
         ($past(clean[0][`MSC_SIG_GI3]) ~^ $past(gi3_lvl_q[0])))))
    else $error("spare input three not independent");
  filt_delay_a: assert property (
    (filt_code_q[0] == 3'h0 |-> f_delay(filt_code_q[0]) == CW'(FILT_SHORT_CYC)) and
    (filt_code_q[0] == 3'h7 |-> f_delay(filt_code_q[0]) == CW'(FILT_LONG_CYC * 64)))
    else $error("filter delay table is wrong");
endmodule : msc_top

// ---- tb/msc_drive_model.sv ----
// Purpose: Drive plus encoder on the far side: each step moves one quadrature edge.
// Assumes: Pulse/direction format 2, pulse high, direction high is forward.
// Notes:   Encoder lines are always driven, so no released state exists.
`timescale 1ns/1ps
module msc_drive_model #(
  parameter int A = 4
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [A-1:0] step_pin,
  input  wire logic [A-1:0] dir_pin,
  output logic      [A-1:0] enc_a,
  output logic      [A-1:0] enc_b
);
  logic [A-1:0][1:0] ph_q;
  logic [A-1:0]      prev_q;
  // Gray sequence with A leading B when moving forward
  always_comb for (int i = 0; i < A; i++) begin
    enc_a[i] = ph_q[i][1] ^ ph_q[i][0];
    enc_b[i] = ph_q[i][1];
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ph_q   <= '0;
      prev_q <= '0;
    end else begin
      prev_q <= step_pin;
      for (int i = 0; i < A; i++) if (step_pin[i] && !prev_q[i]) ph_q[i] <= dir_pin[i] ? ph_q[i] + 2'h1 : ph_q[i] - 2'h1;
    end
  end
endmodule : msc_drive_model

// ---- tb/motion_signal_conditioning_bench.sv ----
// Purpose: Self-checking bench for msc_top with a drive model on axis pulses.
// Assumes: Short filter counts so the filter settles in a few cycles.
// Notes:   Pulse results are queued by the driver and compared by a monitor.
`timescale 1ns/1ps
`include "msc_regs.svh"
module motion_signal_conditioning_bench;
  import msc_pkg::*;
  localparam int A = 4;
  localparam logic [1:0] FE [6] = '{2'b10, 2'b01, 2'b11, 2'b10, 2'b01, 2'b00};
  logic mclk = 0, nrst = 0, sel_wr = 0, sel_settled_en = 0, sel_settled_lvl = 0;
  logic sel_fault_en = 0, sel_fault_lvl = 0, sel_gi3_en = 0, sel_gi3_lvl = 0;
  logic emergency_stop_input = 1;
  logic [A-1:0] cmd_pulse = '0, cmd_dir = '0, limit_pol = '1, home_pol = '0, approach_pol = '0;
  logic [A-1:0] zphase_pol = '0, power_pol = '0, power_on = '0, sel_axes = '0;
  logic [A-1:0] home_sensor_pin = '0, approach_sensor_pin = '0, z_phase_input = '0;
  logic [A-1:0] settled_pin = '0, fault_pin = '0, general_input_three = '0;
  logic [3*A-1:0] pulse_mode = '0;
  logic [2*A-1:0] travel_limit_pair = '0, manual_pulse_inputs = '0;
  logic [1:0] sel_enc_div = '0;
  logic [`MSC_FILT_GROUPS-1:0] sel_filt_en = '0;
  msc_enc_e sel_enc_mode = MSC_ENC_QUAD;
  msc_code_t sel_filt_code = '0;
  msc_stop_e sel_stop_mode = MSC_STOP_IMMED;
  wire [A-1:0] enc_a, enc_b, pulse_a_q, pulse_b_q, pulse_taken_q, decel_req_q, drive_power_q;
  wire [A-1:0] limit_pos_act_q, limit_neg_act_q, home_act_q, approach_act_q, zphase_act_q;
  wire [A-1:0] settled_ok_q, fault_act_q, gi3_act_q, manual_up_q, manual_dn_q;
  wire         estop_act_q;
  wire [32*A-1:0] enc_count_q;
  int fail_count = 0, checks = 0, cyc = 0;
  logic [31:0] rs = 32'h0001_5945;
  // Mode switches in the format loop also move the drive, so count from a snapshot
  logic [31:0] base;
  logic [1:0] exp_q [$];
  msc_top #(.FILT_SHORT_CYC(4), .FILT_LONG_CYC(16)) dut (.*);
  msc_drive_model #(.A(A)) far (.mclk(mclk), .nrst(nrst), .step_pin(pulse_a_q),
    .dir_pin(pulse_b_q), .enc_a(enc_a), .enc_b(enc_b));
  initial forever #5 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // Step axis 0; a blocked step queues nothing, so any pulse then is unexpected
  task automatic step(input logic d, input logic [1:0] e, input logic push);
    cmd_dir[0]   <= d;
    cmd_pulse[0] <= 1'b1;
    if (push) exp_q.push_back(e);
    @(posedge mclk);
    cmd_pulse[0] <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : step
  always @(negedge mclk) if (pulse_taken_q[0] === 1'b1) begin
    if (exp_q.size() == 0) chk(1'b0, "unexpected pulse");
    else chk({pulse_a_q[0], pulse_b_q[0]} === exp_q.pop_front(), "pulse lines");
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (8) @(posedge mclk);
    for (int f = 0; f < 6; f++) begin
      pulse_mode[2:0] <= 3'(f);
      @(posedge mclk);
      step(1'b1, FE[f], 1'b1);
    end
    pulse_mode <= {A{3'h2}};
    @(posedge mclk);
    repeat (6) @(posedge mclk);
    base = enc_count_q[31:0];
    repeat (5) step(1'b1, 2'b11, 1'b1);
    repeat (2) step(1'b0, 2'b10, 1'b1);
    repeat (8) @(posedge mclk);
    chk(enc_count_q[31:0] - base === 32'h3, "encoder count");
    rs = xs(rs);
    home_pol <= rs[3:0];
    home_sensor_pin <= rs[7:4];
    power_on <= rs[11:8];
    power_pol <= rs[15:12];
    zphase_pol <= rs[19:16];
    z_phase_input <= rs[23:20];
    manual_pulse_inputs <= 8'h5a;
    repeat (10) @(posedge mclk);
    chk(zphase_act_q === ~(rs[23:20] ^ rs[19:16]), "index polarity");
    chk(manual_up_q === 4'hc && manual_dn_q === 4'h3, "manual inputs");
    chk(estop_act_q === 1'b0, "emergency stop idle");
    chk(home_act_q === ~(rs[7:4] ^ rs[3:0]), "home polarity");
    chk(drive_power_q === ~(rs[11:8] ^ rs[15:12]), "power polarity");
    sel_axes <= 4'h4;
    sel_filt_en <= 5'h01;
    sel_wr <= 1'b1;
    @(posedge mclk);
    sel_axes <= 4'h1;
    sel_filt_en <= 5'h00;
    {sel_fault_en, sel_fault_lvl, sel_gi3_en} <= 3'b111;
    @(posedge mclk);
    sel_wr <= 1'b0;
    fault_pin <= '1;
    approach_sensor_pin <= 4'h4;
    repeat (2) @(posedge mclk);
    approach_sensor_pin <= 4'h0;
    repeat (12) @(posedge mclk);
    chk(approach_act_q[2] === 1'b1, "glitch passed");
    chk(fault_act_q === 4'h1, "fault select");
    chk(gi3_act_q === 4'h1, "spare select");
    approach_sensor_pin <= 4'h4;
    repeat (15) @(posedge mclk);
    chk(approach_act_q[2] === 1'b0, "filtered change");
    step(1'b1, 2'b11, 1'b0);
    sel_fault_en <= 1'b0;
    sel_fault_lvl <= 1'b0;
    {sel_settled_en, sel_settled_lvl} <= 2'h3;
    sel_stop_mode <= MSC_STOP_DECEL;
    sel_enc_div <= 2'h2;
    sel_filt_en <= 5'h01;
    sel_wr <= 1'b1;
    travel_limit_pair[1:0] <= 2'h3;
    @(posedge mclk);
    sel_wr <= 1'b0;
    repeat (14) @(posedge mclk);
    chk(limit_pos_act_q === 4'h1 && limit_neg_act_q === 4'h1, "limit flags");
    chk(settled_ok_q === 4'he, "settled enable");
    step(1'b0, 2'b10, 1'b1);
    chk(decel_req_q === 4'h1, "decelerating stop");
    sel_stop_mode <= MSC_STOP_IMMED;
    sel_enc_mode <= MSC_ENC_UPDN;
    sel_wr <= 1'b1;
    @(posedge mclk);
    sel_wr <= 1'b0;
    step(1'b1, 2'b11, 1'b0);
    travel_limit_pair <= '0;
    repeat (14) @(posedge mclk);
    repeat (4) step(1'b1, 2'b11, 1'b1);
    chk(exp_q.size() == 0, "queue left over");
    report_and_stop();
  end
endmodule : motion_signal_conditioning_bench
